/* vam_top.sv */
`timescale 1ns/1ns
`default_nettype none
module vam_top #(
   parameter int unsigned TICK_CYC      = vam_pkg::VAM_TICK_CYC,
   parameter int unsigned HEALTHY_TICKS = vam_pkg::VAM_HEALTHY_TICKS
) (
   // Clock and reset
   input  wire logic                            i_clk_sys,
   input  wire logic                            i_rst_b,
   // Register port
   input  wire logic [3:0]                      i_addr,
   input  wire logic [15:0]                     i_wdata,
   input  wire logic                            i_wr,
   input  wire logic                            i_rd,
   output logic [15:0]                          o_rdata,
   output logic                                 o_irq,
   // Measurements, same clock domain
   input  wire logic [vam_pkg::VAM_MAG_W-1:0]   i_volt_mag [vam_pkg::VAM_CH_N],
   input  wire logic [vam_pkg::VAM_ANG_W-1:0]   i_volt_ang [vam_pkg::VAM_CH_N],
   input  wire logic [vam_pkg::VAM_MAG_W-1:0]   i_curr_mag [vam_pkg::VAM_CH_N],
   // External block pin
   input  wire logic                            i_block,
   // Reference to protection stages
   output logic [vam_pkg::VAM_MAG_W-1:0]        o_ref_mag [vam_pkg::VAM_CH_N],
   output logic [vam_pkg::VAM_ANG_W-1:0]        o_ref_ang [vam_pkg::VAM_CH_N],
   output logic                                 o_hold_active,
   output logic                                 o_prot_block,
   output logic                                 o_cycle_start
);
   import vam_pkg::*;
   vam_if cfg ();
   vam_regs u_regs (
      .i_clk_sys (i_clk_sys),
      .i_rst_b   (i_rst_b),
      .i_addr    (i_addr),
      .i_wdata   (i_wdata),
      .i_wr      (i_wr),
      .i_rd      (i_rd),
      .o_rdata   (o_rdata),
      .o_irq     (o_irq),
      .cfg       (cfg)
   );

   function automatic logic all_below(input logic [VAM_MAG_W-1:0] m [VAM_CH_N],
                                      input logic [VAM_MAG_W-1:0] t);
      logic r;
      r = 1'b1;
      for (int k = 0; k < VAM_CH_N; k++) begin
         if (m[k] >= t) r = 1'b0;
      end
      return r;
   endfunction

   // Strict compare, no wrap when the level is at full scale
   function automatic logic any_above(input logic [VAM_MAG_W-1:0] m [VAM_CH_N],
                                      input logic [VAM_MAG_W-1:0] t);
      logic r;
      r = 1'b0;
      for (int k = 0; k < VAM_CH_N; k++) begin
         if (m[k] > t) r = 1'b1;
      end
      return r;
   endfunction

   // ==========================================
   // Processing cycle divider
   logic [31:0] div_r;
   logic        tick;
   assign tick = (div_r == TICK_CYC - 1);
   assign o_cycle_start = tick;
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) div_r <= '0;
      else if (tick) div_r <= '0;
      else div_r <= div_r + 32'd1;
   end

   // ==========================================
   // Block pin synchroniser, sampled per cycle
   logic blk_s1_r;
   logic blk_s2_r;
   logic blk_r;
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         blk_s1_r <= 1'b0;
         blk_s2_r <= 1'b0;
         blk_r    <= 1'b0;
      end else begin
         blk_s1_r <= i_block;
         blk_s2_r <= blk_s1_r;
         if (tick) blk_r <= blk_s2_r;
      end
   end

   // ==========================================
   // Entry conditions
   logic v_low;
   logic i_high;
   logic entry_ok;
   assign v_low  = all_below(i_volt_mag, cfg.thr);
   assign i_high = any_above(i_curr_mag, cfg.ilvl);
   assign entry_ok = cfg.enable && v_low && !blk_r
                     && (!cfg.qual_en || i_high);

   // ==========================================
   // Healthy period counter and angle tracking
   // Angles are copied only while healthy, so the
   // held value is the last pre-collapse sample.
   vam_state_t state_r;
   logic [31:0] healthy_r;
   logic        armed;
   logic [VAM_ANG_W-1:0] ang_r [VAM_CH_N];
   assign armed = (healthy_r >= HEALTHY_TICKS);
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) healthy_r <= '0;
      else if (tick) begin
         if (v_low) healthy_r <= '0;
         else if (!armed) healthy_r <= healthy_r + 32'd1;
      end
   end

   genvar g;
   generate
      for (g = 0; g < VAM_CH_N; g++) begin : g_ang
         always_ff @(posedge i_clk_sys) begin
            if (!i_rst_b) ang_r[g] <= VAM_ANG_ZERO;
            else if (tick && !v_low && state_r != VAM_HOLD) begin
               // Out-of-range angles clipped to 0.00 deg
               if (i_volt_ang[g] >= VAM_ANG_MAX) ang_r[g] <= VAM_ANG_ZERO;
               else ang_r[g] <= i_volt_ang[g];
            end
         end
      end
   endgenerate

   // ==========================================
   // Hold state machine and duration timer
   logic [VAM_TICK_W-1:0] dur_r;
   logic ev_on_r;
   logic ev_off_r;
   logic ev_exp_r;
   logic ev_blk_r;
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         state_r  <= VAM_IDLE;
         dur_r    <= '0;
         ev_on_r  <= 1'b0;
         ev_off_r <= 1'b0;
         ev_exp_r <= 1'b0;
         ev_blk_r <= 1'b0;
      end else begin
         ev_on_r  <= 1'b0;
         ev_off_r <= 1'b0;
         ev_exp_r <= 1'b0;
         ev_blk_r <= 1'b0;
         if (tick) begin
            case (state_r)
               VAM_IDLE: begin
                  if (armed && !v_low) state_r <= VAM_ARMED;
               end
               VAM_ARMED: begin
                  if (entry_ok) begin
                     state_r <= VAM_HOLD;
                     dur_r   <= '0;
                     ev_on_r <= 1'b1;
                  end else if (v_low) begin
                     // Collapse without qualifiers disarms
                     state_r <= VAM_IDLE;
                     ev_blk_r <= blk_r;
                  end
               end
               VAM_HOLD: begin
                  if (blk_r || !cfg.enable) begin
                     state_r  <= VAM_IDLE;
                     ev_off_r <= 1'b1;
                     ev_blk_r <= blk_r;
                  end else if (!v_low) begin
                     state_r  <= VAM_IDLE;
                     ev_off_r <= 1'b1;
                  end else if (dur_r + 16'h0001 >= cfg.lim) begin
                     state_r  <= VAM_EXPIRED;
                     ev_off_r <= 1'b1;
                     ev_exp_r <= 1'b1;
                  end else begin
                     dur_r <= dur_r + 16'h0001;
                  end
               end
               VAM_EXPIRED: begin
                  // Stay blocked until voltage recovers
                  if (!v_low) state_r <= VAM_IDLE;
               end
               default: state_r <= VAM_IDLE;
            endcase
         end
      end
   end
   assign cfg.ev_on  = ev_on_r;
   assign cfg.ev_off = ev_off_r;
   assign cfg.ev_exp = ev_exp_r;
   assign cfg.ev_blk = ev_blk_r;
   assign cfg.state  = state_r;

   // ==========================================
   // Outputs
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         o_hold_active <= 1'b0;
         o_prot_block  <= 1'b0;
      end else begin
         o_hold_active <= (state_r == VAM_HOLD);
         o_prot_block  <= (state_r == VAM_EXPIRED);
      end
   end
   generate
      for (g = 0; g < VAM_CH_N; g++) begin : g_ref
         always_ff @(posedge i_clk_sys) begin
            if (!i_rst_b) begin
               o_ref_mag[g] <= '0;
               o_ref_ang[g] <= VAM_ANG_ZERO;
            end else if (state_r == VAM_HOLD) begin
               o_ref_mag[g] <= cfg.thr;
               o_ref_ang[g] <= ang_r[g];
            end else begin
               o_ref_mag[g] <= i_volt_mag[g];
               o_ref_ang[g] <= (i_volt_ang[g] >= VAM_ANG_MAX) ? VAM_ANG_ZERO : i_volt_ang[g];
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

/* vam_pkg.sv */
package vam_pkg;
   // ==========================================
   // Widths
   localparam int unsigned VAM_MAG_W   = 16;
   localparam int unsigned VAM_ANG_W   = 16;
   localparam int unsigned VAM_CH_N    = 3;
   localparam int unsigned VAM_TICK_W  = 16;
   // ==========================================
   // Clock and cycle timing
   localparam int unsigned VAM_CLK_HZ      = 100_000_000;
   localparam int unsigned VAM_TICK_US     = 5000;
   localparam int unsigned VAM_TICK_CYC    = VAM_TICK_US * (VAM_CLK_HZ / 1_000_000);
   localparam int unsigned VAM_HEALTHY_MS  = 2500;
   localparam int unsigned VAM_HEALTHY_TICKS = VAM_HEALTHY_MS * 1000 / VAM_TICK_US;
   // ==========================================
   // Settings, in steps of their resolution
   localparam logic [VAM_MAG_W-1:0]  VAM_THR_RST     = 16'h05DC; // 15.00 %
   localparam logic [VAM_MAG_W-1:0]  VAM_ILVL_RST    = 16'h0064; // 1.00 xIn
   localparam logic [VAM_TICK_W-1:0] VAM_LIM_RST     = 16'h0BB8; // 15.000 s
   localparam logic [VAM_TICK_W-1:0] VAM_LIM_MIN     = 16'h0004; // 0.020 s
   localparam logic [VAM_TICK_W-1:0] VAM_LIM_MAX     = 16'h2710; // 50.000 s
   localparam logic [VAM_ANG_W-1:0]  VAM_ANG_MAX     = 16'h8CA0; // 360.00 deg
   localparam logic [VAM_ANG_W-1:0]  VAM_ANG_ZERO    = 16'h0000;
   // ==========================================
   // Register map
   localparam logic [3:0] VAM_A_CTRL   = 4'h0;
   localparam logic [3:0] VAM_A_THR    = 4'h1;
   localparam logic [3:0] VAM_A_ILVL   = 4'h2;
   localparam logic [3:0] VAM_A_LIM    = 4'h3;
   localparam logic [3:0] VAM_A_STAT   = 4'h4;
   localparam logic [3:0] VAM_A_IRQ    = 4'h5;
   localparam logic [3:0] VAM_A_MASK   = 4'h6;
   localparam int unsigned VAM_CTRL_EN   = 0;
   localparam int unsigned VAM_CTRL_QUAL = 1;
   localparam int unsigned VAM_EV_N      = 4;
   localparam int unsigned VAM_EV_ON     = 0;
   localparam int unsigned VAM_EV_OFF    = 1;
   localparam int unsigned VAM_EV_EXP    = 2;
   localparam int unsigned VAM_EV_BLK    = 3;

   typedef enum logic [1:0] {
      VAM_IDLE    = 2'b00,
      VAM_ARMED   = 2'b01,
      VAM_HOLD    = 2'b11,
      VAM_EXPIRED = 2'b10
   } vam_state_t;
endpackage

/* vam_if.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Settings and status between core and regs
interface vam_if;
   logic                        enable;
   logic                        qual_en;
   logic [vam_pkg::VAM_MAG_W-1:0]  thr;
   logic [vam_pkg::VAM_MAG_W-1:0]  ilvl;
   logic [vam_pkg::VAM_TICK_W-1:0] lim;
   logic                        ev_on;
   logic                        ev_off;
   logic                        ev_exp;
   logic                        ev_blk;
   vam_pkg::vam_state_t         state;
   modport core (input enable, qual_en, thr, ilvl, lim, output ev_on, ev_off, ev_exp, ev_blk, state);
   modport regs (output enable, qual_en, thr, ilvl, lim, input ev_on, ev_off, ev_exp, ev_blk, state);
endinterface
`default_nettype wire

/* vam_regs.sv */
`timescale 1ns/1ns
`default_nettype none
module vam_regs (
   // Clock and reset
   input  wire logic                 i_clk_sys,
   input  wire logic                 i_rst_b,
   // Register port
   input  wire logic [3:0]           i_addr,
   input  wire logic [15:0]          i_wdata,
   input  wire logic                 i_wr,
   input  wire logic                 i_rd,
   output logic [15:0]               o_rdata,
   output logic                      o_irq,
   // Core side
   vam_if.regs                       cfg
);
   import vam_pkg::*;
   logic [1:0]          ctrl_r;
   logic [15:0]         thr_r;
   logic [15:0]         ilvl_r;
   logic [15:0]         lim_r;
   logic [VAM_EV_N-1:0] irq_r;
   logic [VAM_EV_N-1:0] mask_r;
   logic [VAM_EV_N-1:0] ev;
   assign ev = {cfg.ev_blk, cfg.ev_exp, cfg.ev_off, cfg.ev_on};
   assign cfg.enable  = ctrl_r[VAM_CTRL_EN];
   assign cfg.qual_en = ctrl_r[VAM_CTRL_QUAL];
   assign cfg.thr  = thr_r;
   assign cfg.ilvl = ilvl_r;
   assign cfg.lim  = lim_r;
   assign o_irq = |(irq_r & mask_r);
   // ==========================================
   // Settings
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         ctrl_r <= 2'h1;
         thr_r  <= VAM_THR_RST;
         ilvl_r <= VAM_ILVL_RST;
         lim_r  <= VAM_LIM_RST;
         mask_r <= '0;
      end else if (i_wr) begin
         if (i_addr == VAM_A_CTRL) begin
            ctrl_r <= i_wdata[1:0];
         end else if (i_addr == VAM_A_THR) begin
            thr_r <= i_wdata;
         end else if (i_addr == VAM_A_ILVL) begin
            ilvl_r <= i_wdata;
         end else if (i_addr == VAM_A_LIM) begin
            // Clamp to the legal range
            if (i_wdata < VAM_LIM_MIN) lim_r <= VAM_LIM_MIN;
            else if (i_wdata > VAM_LIM_MAX) lim_r <= VAM_LIM_MAX;
            else lim_r <= i_wdata;
         end else if (i_addr == VAM_A_MASK) begin
            mask_r <= i_wdata[VAM_EV_N-1:0];
         end
      end
   end
   // ==========================================
   // Sticky events; a new event beats read clear
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         irq_r <= '0;
      end else if (i_rd && i_addr == VAM_A_IRQ) begin
         irq_r <= ev;
      end else begin
         irq_r <= irq_r | ev;
      end
   end
   // ==========================================
   // Read data
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         o_rdata <= '0;
      end else if (i_rd) begin
         if (i_addr == VAM_A_CTRL) o_rdata <= {14'h0000, ctrl_r};
         else if (i_addr == VAM_A_THR) o_rdata <= thr_r;
         else if (i_addr == VAM_A_ILVL) o_rdata <= ilvl_r;
         else if (i_addr == VAM_A_LIM) o_rdata <= lim_r;
         else if (i_addr == VAM_A_STAT) o_rdata <= {14'h0000, cfg.state};
         else if (i_addr == VAM_A_IRQ) o_rdata <= {12'h000, irq_r};
         else if (i_addr == VAM_A_MASK) o_rdata <= {12'h000, mask_r};
         else o_rdata <= '0;
      end else begin
         o_rdata <= '0;
      end
   end
endmodule
`default_nettype wire

/* vam_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module vam_chk
   import vam_pkg::*;
#(
   parameter int TICK_CYC = 10
) (
   // Clock, reset, register port
   input wire logic        i_clk_sys,
   input wire logic        i_rst_b,
   input wire logic [3:0]  i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [15:0] o_rdata,
   // Measurements and outputs
   input wire logic [15:0] i_curr_mag [3],
   input wire logic        i_block,
   input wire logic [15:0] o_ref_mag [3],
   input wire logic [15:0] o_ref_ang [3],
   input wire logic        o_hold_active,
   input wire logic        o_prot_block,
   input wire logic        o_cycle_start
);
   // ==========================================
   // Shadow of settings written by software
   logic [15:0] thr_r;
   logic [15:0] ilvl_r;
   logic [15:0] lim_r;
   logic [1:0]  ctrl_r;
   int          hold_cnt_r;
   int          blk_cnt_r;
   int          tick_gap_r;
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         thr_r  <= VAM_THR_RST;
         ilvl_r <= VAM_ILVL_RST;
         lim_r  <= VAM_LIM_RST;
         ctrl_r <= 2'h1;
      end else if (i_wr) begin
         if (i_addr == VAM_A_CTRL) ctrl_r <= i_wdata[1:0];
         if (i_addr == VAM_A_THR) thr_r <= i_wdata;
         if (i_addr == VAM_A_ILVL) ilvl_r <= i_wdata;
         if (i_addr == VAM_A_LIM) lim_r <= (i_wdata < VAM_LIM_MIN) ? VAM_LIM_MIN :
                                           (i_wdata > VAM_LIM_MAX) ? VAM_LIM_MAX : i_wdata;
      end
   end
   // ==========================================
   // Run lengths of hold and of the block pin
   always_ff @(posedge i_clk_sys) begin
      hold_cnt_r <= (!i_rst_b || !o_hold_active) ? 0 : hold_cnt_r + 1;
      blk_cnt_r  <= (!i_rst_b || !i_block) ? 0 : blk_cnt_r + 1;
      // Counted, as the real cycle is far too long for a delay
      tick_gap_r <= (!i_rst_b || o_cycle_start) ? 0 : tick_gap_r + 1;
   end
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_b);
   sequence s_hold_start;
      $rose(o_hold_active);
   endsequence
   // ==========================================
   // Checks
   AST_TICK_PERIOD: assert property (o_cycle_start ? (tick_gap_r == TICK_CYC - 1) : (tick_gap_r < TICK_CYC - 1))
      else $error("cycle start pulse spacing wrong");
   AST_EN_GATE: assert property (s_hold_start |-> ctrl_r[0])
      else $error("hold entered while disabled");
   AST_QUAL_CURR: assert property (s_hold_start ##0 ctrl_r[1] |-> $past(i_curr_mag[0], 2) > ilvl_r
      || $past(i_curr_mag[1], 2) > ilvl_r || $past(i_curr_mag[2], 2) > ilvl_r)
      else $error("hold entered without current");
   AST_HOLD_MAG: assert property (o_hold_active |-> o_ref_mag[0] == thr_r && o_ref_mag[1] == thr_r
      && o_ref_mag[2] == thr_r)
      else $error("hold amplitude not threshold");
   AST_ANG_FROZEN: assert property (o_hold_active && $past(o_hold_active) |-> $stable(o_ref_ang[0])
      && $stable(o_ref_ang[1]) && $stable(o_ref_ang[2]))
      else $error("held angle moved");
   AST_HOLD_LIMIT: assert property (hold_cnt_r <= (int'(lim_r) + 2) * TICK_CYC)
      else $error("hold outlived limit");
   AST_EXP_AFTER_HOLD: assert property ($rose(o_prot_block) |-> $past(o_hold_active))
      else $error("protection block without hold");
   AST_EXP_EXCL: assert property (!(o_prot_block && o_hold_active))
      else $error("hold and block together");
   // Sync, wait for the sampling tick, then the next tick acts on it
   AST_BLOCK_EXIT: assert property (blk_cnt_r >= 2 * TICK_CYC + 4 |-> !o_hold_active)
      else $error("hold kept while blocked");
   AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
      else $error("read data outside read slot");
endmodule
bind vam_top vam_chk #(.TICK_CYC(TICK_CYC)) chk_u (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_curr_mag(i_curr_mag), .i_block(i_block),
   .o_ref_mag(o_ref_mag), .o_ref_ang(o_ref_ang), .o_hold_active(o_hold_active), .o_prot_block(o_prot_block),
   .o_cycle_start(o_cycle_start));
`default_nettype wire

/* vam_meas_model.sv */
`timescale 1ns/1ns
`default_nettype none
module vam_meas_model (
   // Control from bench
   input  wire logic       i_clk_sys,
   input  wire logic [2:0] i_low_sel,
   input  wire logic       i_curr_hi,
   // Measurement channels
   output logic [15:0]     o_volt_mag [3],
   output logic [15:0]     o_volt_ang [3],
   output logic [15:0]     o_curr_mag [3]
);
   logic [15:0] drift_r = 16'h0000;
   initial begin
      for (int k = 0; k < 3; k++) begin
         o_volt_mag[k] = 16'h2710;
         o_volt_ang[k] = 16'h1123 + 16'h1000 * 16'(k);
         o_curr_mag[k] = 16'h0032;
      end
   end
   // Collapse of all three channels gives meaningless angles, so they wander every clock
   always @(posedge i_clk_sys) begin
      drift_r <= (drift_r > 16'h8B00) ? 16'h0000 : drift_r + 16'h0101;
      for (int k = 0; k < 3; k++) begin
         o_volt_mag[k] <= i_low_sel[k] ? 16'h0064 : 16'h2710;
         o_volt_ang[k] <= (&i_low_sel) ? drift_r : 16'h1123 + 16'h1000 * 16'(k);
         o_curr_mag[k] <= i_curr_hi ? 16'h00C8 : 16'h0032;
      end
   end
endmodule
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import vam_pkg::*;
   localparam int TICK = 10;
   logic        i_clk_sys, i_rst_b, i_wr, i_rd, i_block, o_irq, o_hold_active, o_prot_block, curr_hi;
   logic [3:0]  i_addr;
   logic [2:0]  low_sel;
   logic [15:0] i_wdata, o_rdata, d;
   logic [15:0] i_volt_mag [3], i_volt_ang [3], i_curr_mag [3], o_ref_mag [3], o_ref_ang [3];
   int          num_errors = 0, total_checks = 0, cyc = 0;
   initial begin
      i_clk_sys = 1'b0;
      forever #5 i_clk_sys = ~i_clk_sys;
   end
   vam_meas_model src_u (.i_clk_sys(i_clk_sys), .i_low_sel(low_sel), .i_curr_hi(curr_hi),
      .o_volt_mag(i_volt_mag), .o_volt_ang(i_volt_ang), .o_curr_mag(i_curr_mag));
   vam_top #(.TICK_CYC(TICK), .HEALTHY_TICKS(4)) dut_u (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
      .i_volt_mag(i_volt_mag), .i_volt_ang(i_volt_ang), .i_curr_mag(i_curr_mag), .i_block(i_block),
      .o_ref_mag(o_ref_mag), .o_ref_ang(o_ref_ang), .o_hold_active(o_hold_active),
      .o_prot_block(o_prot_block), .o_cycle_start());
   // ==========================================
   // Tasks
   task automatic complete_run();
      if (num_errors == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge i_clk_sys);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= v;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge i_clk_sys);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [15:0] exp, input string name);
      rd(a);
      chk(name, d, exp);
   endtask
   task automatic meas(input logic [2:0] l, input logic c, input logic b);
      @(posedge i_clk_sys);
      low_sel <= l;
      curr_hi <= c;
      i_block <= b;
   endtask
   task automatic ticks(input int n);
      repeat (n * TICK) @(posedge i_clk_sys);
      #1;
   endtask
   // Ceiling well above the roughly 600 cycles the sequence needs
   always @(posedge i_clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         complete_run();
      end
   end
   // ==========================================
   // Sequence
   initial begin
      {i_rst_b, i_wr, i_rd, i_block, curr_hi, low_sel, i_addr, i_wdata} = '0;
      repeat (6) @(posedge i_clk_sys);
      i_rst_b <= 1'b1;
      rdc(VAM_A_CTRL, 16'h0001, "ctrl");
      rdc(VAM_A_THR, VAM_THR_RST, "thr");
      rdc(VAM_A_ILVL, VAM_ILVL_RST, "ilvl");
      rdc(VAM_A_LIM, VAM_LIM_RST, "lim");
      rdc(VAM_A_MASK, 16'h0000, "mask");
      wr(4'hF, 16'hFFFF);
      rdc(4'hF, 16'h0000, "unmapped");
      wr(VAM_A_LIM, 16'h0001);
      rdc(VAM_A_LIM, VAM_LIM_MIN, "lim_min");
      wr(VAM_A_LIM, 16'hFFFF);
      rdc(VAM_A_LIM, VAM_LIM_MAX, "lim_max");
      wr(VAM_A_LIM, 16'h0006);
      wr(VAM_A_MASK, 16'h000F);
      ticks(6);
      meas(3'b011, 1'b0, 1'b0);
      ticks(3);
      chk("hold_partial", o_hold_active, 16'h0000);
      meas(3'b111, 1'b0, 1'b0);
      ticks(3);
      chk("hold_on", o_hold_active, 16'h0001);
      chk("irq_on", o_irq, 16'h0001);
      for (int k = 0; k < 3; k++) begin
         chk("ref_mag", o_ref_mag[k], VAM_THR_RST);
         chk("ref_ang", o_ref_ang[k], 16'h1123 + 16'h1000 * 16'(k));
      end
      rdc(VAM_A_IRQ, 16'h0001, "ev_on");
      rdc(VAM_A_STAT, 16'h0003, "stat_hold");
      ticks(1);
      chk("hold_kept", o_hold_active, 16'h0001);
      ticks(3);
      chk("expired_hold", o_hold_active, 16'h0000);
      chk("prot_block", o_prot_block, 16'h0001);
      rdc(VAM_A_STAT, 16'h0002, "stat_exp");
      wr(VAM_A_MASK, 16'h0000);
      #1 chk("irq_masked", o_irq, 16'h0000);
      rd(VAM_A_IRQ);
      chk("ev_exp", d, 16'h0006);
      rdc(VAM_A_IRQ, 16'h0000, "irq_cleared");
      meas(3'b000, 1'b0, 1'b0);
      ticks(2);
      chk("prot_released", o_prot_block, 16'h0000);
      for (int k = 0; k < 3; k++) begin
         chk("ref_mag_live", o_ref_mag[k], 16'h2710);
         chk("ref_ang_live", o_ref_ang[k], 16'h1123 + 16'h1000 * 16'(k));
      end
      meas(3'b111, 1'b0, 1'b0);
      ticks(3);
      chk("short_healthy", o_hold_active, 16'h0000);
      rdc(VAM_A_STAT, 16'h0000, "stat_idle");
      meas(3'b000, 1'b0, 1'b0);
      ticks(6);
      wr(VAM_A_CTRL, 16'h0003);
      meas(3'b111, 1'b0, 1'b0);
      ticks(3);
      chk("qual_low", o_hold_active, 16'h0000);
      // A collapse without current disarms, so rebuild the healthy run
      meas(3'b000, 1'b0, 1'b0);
      ticks(6);
      meas(3'b111, 1'b1, 1'b0);
      ticks(3);
      chk("qual_high", o_hold_active, 16'h0001);
      meas(3'b111, 1'b1, 1'b1);
      ticks(3);
      chk("blocked", o_hold_active, 16'h0000);
      rdc(VAM_A_IRQ, 16'h000B, "ev_blk");
      meas(3'b000, 1'b0, 1'b0);
      ticks(6);
      wr(VAM_A_CTRL, 16'h0000);
      meas(3'b111, 1'b0, 1'b0);
      ticks(3);
      chk("disabled", o_hold_active, 16'h0000);
      complete_run();
   end
endmodule
`default_nettype wire
